// ---- lvdstx_pkg.sv ----
/*
  Constants for the serialising display-link transmitter: pixel field layout,
  lane and slot counts, forwarded-clock pattern, lock and loss timing.
  Assumes a 200 MHz system clock; all times are converted from it here.
*/
package lvdstx_pkg;

  // Pixel word layout
  localparam int unsigned PIX_BITS       = 21;
  localparam int unsigned COLOUR_W       = 6;
  localparam int unsigned RED_LSB        = 0;
  localparam int unsigned GREEN_LSB      = 6;
  localparam int unsigned BLUE_LSB       = 12;
  localparam int unsigned LINE_SYNC_BIT  = 18;
  localparam int unsigned FRAME_SYNC_BIT = 19;
  localparam int unsigned DATA_VALID_BIT = 20;

  // Serial framing
  localparam int unsigned LANES = 3;
  localparam int unsigned SLOTS = 7;
  localparam logic [6:0]  FWD_CLK_PATTERN = 7'h63;

  // Clock and timing
  localparam int unsigned MCLK_PERIOD_PS = 5000;
  localparam int unsigned LOCK_MAX_MS    = 10;
  localparam int unsigned LOCK_MAX_CYC   = LOCK_MAX_MS * (1000000000 / MCLK_PERIOD_PS);
  localparam int unsigned PIX_LOSS_NS    = 2000;
  localparam int unsigned PIX_LOSS_CYC   = (PIX_LOSS_NS * 1000) / MCLK_PERIOD_PS;

  // Acquisition
  localparam int unsigned PER_W       = 16;
  localparam int unsigned LOCK_STABLE = 4;
  localparam int unsigned TOL_SHIFT   = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ  = 2'b01,
    ST_LOCK = 2'b10
  } lvdstx_state_t;

endpackage

// ---- lvdstx_top.sv ----
/*
  Display-link transmitter core: samples a 21-bit pixel word on the chosen
  edge of the oversampled pixel clock and sends it as seven evenly spaced
  slots on three data lanes, with a forwarded clock on a fourth pair.
  Assumes pixel clock, pixel data and pins are asynchronous to mclk and that
  a pad ring turns each p/n/oe triple into a differential pin.
*/
// Notes on behaviour
// RULE_01: Accept 21 bits: 18 colour, three control.
// RULE_02: Drive three data lanes plus forwarded clock.
// RULE_03: Default capture on falling pixel clock edge.
// RULE_04: Select high captures on rising edge instead.
// RULE_05: Select low or open means falling edge.
// RULE_06: Power-down floats all serial outputs.
// RULE_07: Power-down resets logic, stops lock, idles.
// RULE_08: Any order of clock, data, power-down works.
// RULE_09: Clock stop and restart relocks without power-down.
// RULE_10: Source pulses power-down after unstable clock.
// RULE_11: Track spread-spectrum clock up to five percent.
// RULE_12: Every pixel period sends all 21 bits.
// RULE_13: Seven evenly spaced slots per lane per period.
// RULE_14: Power-down pulses last at least one microsecond.
// RULE_15: Lock within ten milliseconds of stable clock.
// RULE_16: Fixed bit-to-lane table, shared with receiver.
`timescale 1ns/1ps

module lvdstx_top #(
  parameter int unsigned PER_W        = lvdstx_pkg::PER_W,
  parameter int unsigned LOCK_STABLE  = lvdstx_pkg::LOCK_STABLE,
  parameter int unsigned LOSS_CYC     = lvdstx_pkg::PIX_LOSS_CYC,
  parameter int unsigned LOCK_MAX_CYC = lvdstx_pkg::LOCK_MAX_CYC
) (
  input  wire logic                              mclk,
  input  wire logic                              sys_rst,
  input  wire logic                              ce,
  input  wire logic                              pixel_clock_in,
  input  wire logic [lvdstx_pkg::PIX_BITS-1:0]   pixel_parallel_in,
  input  wire logic                              strobe_edge_select,
  input  wire logic                              power_down_n,
  output wire logic [lvdstx_pkg::LANES-1:0]      serial_lane_out_p,
  output wire logic [lvdstx_pkg::LANES-1:0]      serial_lane_out_n,
  output wire logic [lvdstx_pkg::LANES-1:0]      serial_lane_oe,
  output logic                                   forwarded_clock_out_p,
  output logic                                   forwarded_clock_out_n,
  output logic                                   forwarded_clock_oe,
  output logic                                   link_locked
);

  localparam int unsigned LANES = lvdstx_pkg::LANES;
  localparam int unsigned SLOTS = lvdstx_pkg::SLOTS;

  // Elaboration checks
  if (LOSS_CYC < 2 || LOSS_CYC >= (1 << PER_W))
  begin : g_bad_loss
    $error("LOSS_CYC does not fit the period counter");
  end
  if (LOCK_STABLE < 1 || LOCK_STABLE >= 256)
  begin : g_bad_stable
    $error("LOCK_STABLE out of range");
  end
  if ((LOCK_STABLE + 2) * LOSS_CYC > LOCK_MAX_CYC)
  begin : g_bad_lock
    $error("Acquisition cannot finish within the lock time");
  end

  // Input synchronisers
  logic                              clk_s1_q;
  logic                              clk_s2_q;
  logic                              clk_s3_q;
  logic [lvdstx_pkg::PIX_BITS-1:0]   data_s1_q;
  logic [lvdstx_pkg::PIX_BITS-1:0]   data_s2_q;
  logic                              sel_s1_q;
  logic                              sel_s2_q;
  logic                              pd_s1_q;
  logic                              pd_s2_q;

  // Acquisition state
  lvdstx_pkg::lvdstx_state_t         state_q;
  lvdstx_pkg::lvdstx_state_t         state_d;
  logic [PER_W-1:0]                  cnt_q;
  logic [PER_W-1:0]                  period_q;
  logic [PER_W-1:0]                  period_d;
  logic [7:0]                        stable_q;
  logic [7:0]                        stable_d;

  // Serialiser
  logic [2:0]                        slot_q;
  logic [PER_W-1:0]                  acc_q;
  logic [PER_W:0]                    acc_sum;
  logic [SLOTS-1:0]                  sh_q [LANES];
  logic                              lane_p_q [LANES];
  logic                              lane_n_q [LANES];
  logic                              lane_oe_q [LANES];

  // Derived terms
  logic                              strobe;
  logic                              loss;
  logic                              near;
  logic                              powered;
  logic                              tx_on;
  logic [PER_W-1:0]                  meas;
  logic [PER_W-1:0]                  diff;

  // Nothing but the second stage reads a first stage
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      clk_s1_q  <= 1'b0;
      clk_s2_q  <= 1'b0;
      clk_s3_q  <= 1'b0;
      data_s1_q <= '0;
      data_s2_q <= '0;
      sel_s1_q  <= 1'b0;
      sel_s2_q  <= 1'b0;
      pd_s1_q   <= 1'b0;
      pd_s2_q   <= 1'b0;
    end
    else if (ce)
    begin
      clk_s1_q  <= pixel_clock_in;
      clk_s2_q  <= clk_s1_q;
      clk_s3_q  <= clk_s2_q;
      data_s1_q <= pixel_parallel_in; // [RULE_01]
      data_s2_q <= data_s1_q;
      sel_s1_q  <= strobe_edge_select;
      sel_s2_q  <= sel_s1_q;
      pd_s1_q   <= power_down_n;
      pd_s2_q   <= pd_s1_q;
    end
  end

  // Pad pull-down is outside this core; only a firm high picks rising
  assign strobe = sel_s2_q ? (clk_s2_q & ~clk_s3_q)   // [RULE_04]
                           : (~clk_s2_q & clk_s3_q);  // [RULE_03] [RULE_05]

  // Power-down acts as a synchronous reset of everything downstream
  assign powered = pd_s2_q; // [RULE_07]
  assign tx_on   = (state_q == lvdstx_pkg::ST_LOCK);

  // Period counter between strobes; saturates to flag a stopped clock
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q <= '0;
    end
    else if (ce)
    begin
      if (!powered || strobe)
      begin
        cnt_q <= '0;
      end
      else if (cnt_q < LOSS_CYC[PER_W-1:0])
      begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign meas = cnt_q + 1'b1;
  assign loss = (cnt_q == LOSS_CYC[PER_W-1:0]); // [RULE_09]
  assign diff = (meas > period_q) ? (meas - period_q) : (period_q - meas);

  // Tolerance wide enough for spread-spectrum drift, too narrow for a mode change
  assign near = (diff <= (period_q >> lvdstx_pkg::TOL_SHIFT))
                && (meas >= PER_W'(SLOTS)); // [RULE_11]

  // Lock acquisition: needs a run of consistent periods
  always_comb
  begin
    state_d  = state_q;
    period_d = period_q;
    stable_d = stable_q;
    case (state_q)
      lvdstx_pkg::ST_IDLE:
      begin
        stable_d = '0;
        if (strobe)
        begin
          state_d = lvdstx_pkg::ST_ACQ; // [RULE_08]
        end
      end
      lvdstx_pkg::ST_ACQ:
      begin
        if (loss)
        begin
          state_d = lvdstx_pkg::ST_IDLE;
        end
        else if (strobe)
        begin
          period_d = meas;
          if (near)
          begin
            stable_d = stable_q + 1'b1;
            if (stable_q == 8'(LOCK_STABLE - 1))
            begin
              state_d = lvdstx_pkg::ST_LOCK; // [RULE_15]
            end
          end
          else
          begin
            stable_d = '0;
          end
        end
      end
      lvdstx_pkg::ST_LOCK:
      begin
        if (loss)
        begin
          state_d = lvdstx_pkg::ST_IDLE; // [RULE_09]
        end
        else if (strobe)
        begin
          period_d = meas; // [RULE_11]
          if (!near)
          begin
            state_d  = lvdstx_pkg::ST_ACQ; // [RULE_09]
            stable_d = '0;
          end
        end
      end
      default:
      begin
        state_d = lvdstx_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q  <= lvdstx_pkg::ST_IDLE;
      period_q <= '0;
      stable_q <= '0;
    end
    else if (ce)
    begin
      if (!powered)
      begin
        state_q  <= lvdstx_pkg::ST_IDLE; // [RULE_07]
        period_q <= '0;
        stable_q <= '0;
      end
      else
      begin
        state_q  <= state_d;
        period_q <= period_d;
        stable_q <= stable_d;
      end
    end
  end

  // Slot timing: add SLOTS each cycle, step a slot per period wrap
  assign acc_sum = {1'b0, acc_q} + (PER_W + 1)'(SLOTS);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      slot_q <= '0;
      acc_q  <= '0;
    end
    else if (ce)
    begin
      if (!powered || !tx_on || strobe)
      begin
        slot_q <= '0; // [RULE_12]
        acc_q  <= '0;
      end
      else if (acc_sum >= {1'b0, period_q})
      begin
        acc_q <= PER_W'(acc_sum - {1'b0, period_q}); // [RULE_13]
        if (slot_q != 3'(SLOTS - 1))
        begin
          slot_q <= slot_q + 1'b1;
        end
      end
      else
      begin
        acc_q <= acc_sum[PER_W-1:0];
      end
    end
  end

  // Per-lane capture and drive; lane l carries pixel bits 7l to 7l+6
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    always_ff @(posedge mclk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        sh_q[l] <= '0;
      end
      else if (ce)
      begin
        if (!powered)
        begin
          sh_q[l] <= '0;
        end
        else if (strobe)
        begin
          sh_q[l] <= data_s2_q[l*SLOTS +: SLOTS]; // [RULE_16] [RULE_12]
        end
      end
    end

    // Unlocked but powered lanes sit at a steady low instead of noise
    always_ff @(posedge mclk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        lane_p_q[l]  <= 1'b0;
        lane_n_q[l]  <= 1'b0;
        lane_oe_q[l] <= 1'b0;
      end
      else if (ce)
      begin
        lane_oe_q[l] <= powered; // [RULE_06]
        lane_p_q[l]  <= powered && tx_on && sh_q[l][slot_q]; // [RULE_02] [RULE_13]
        lane_n_q[l]  <= powered && !(tx_on && sh_q[l][slot_q]);
      end
    end

    assign serial_lane_out_p[l] = lane_p_q[l];
    assign serial_lane_out_n[l] = lane_n_q[l];
    assign serial_lane_oe[l]    = lane_oe_q[l];
  end

  // Forwarded clock follows the slot pattern of the current pixel period
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      forwarded_clock_out_p <= 1'b0;
      forwarded_clock_out_n <= 1'b0;
      forwarded_clock_oe    <= 1'b0;
      link_locked           <= 1'b0;
    end
    else if (ce)
    begin
      forwarded_clock_oe    <= powered; // [RULE_06]
      forwarded_clock_out_p <= powered && tx_on
                               && lvdstx_pkg::FWD_CLK_PATTERN[slot_q]; // [RULE_02]
      forwarded_clock_out_n <= powered
                               && !(tx_on && lvdstx_pkg::FWD_CLK_PATTERN[slot_q]);
      link_locked           <= powered && tx_on;
    end
  end

endmodule // lvdstx_top

// ---- lvdstx_chk.sv ----
/*
  Checker bound to lvdstx_top: reset, power-down, idle, loss and framing.
  Assumes only the top's ports, one mclk domain, LOSS_CYC handed on.
*/
`timescale 1ns/1ps
module lvdstx_chk #(
  parameter int unsigned LOSS_CYC = 400
) (
  input wire logic                         mclk,
  input wire logic                         sys_rst,
  input wire logic                         ce,
  input wire logic                         pixel_clock_in,
  input wire logic                         power_down_n,
  input wire logic [lvdstx_pkg::LANES-1:0] serial_lane_out_p,
  input wire logic [lvdstx_pkg::LANES-1:0] serial_lane_out_n,
  input wire logic [lvdstx_pkg::LANES-1:0] serial_lane_oe,
  input wire logic                         forwarded_clock_out_p,
  input wire logic                         forwarded_clock_out_n,
  input wire logic                         forwarded_clock_oe,
  input wire logic                         link_locked
);
  logic [15:0] quiet_q;
  logic        pclk_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // Raw pin quiet time; the selected edge can only be older, so it is a safe bound
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      quiet_q <= 16'h0000;
      pclk_q  <= 1'b0;
    end
    else if (ce)
    begin
      pclk_q  <= pixel_clock_in;
      quiet_q <= (pixel_clock_in != pclk_q) ? 16'h0000 :
                 (quiet_q == 16'hffff) ? quiet_q : quiet_q + 16'h0001;
    end

  property p_rst_quiet;
    $fell(sys_rst) |-> serial_lane_oe == '0 && !forwarded_clock_oe && !link_locked;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("driven after reset");
  property p_pd_float;
    (!power_down_n && ce)[*4] |=> serial_lane_oe == '0 && serial_lane_out_p == '0 &&
      serial_lane_out_n == '0 && !forwarded_clock_oe && !link_locked;
  endproperty
  a_pd_float: assert property (p_pd_float) else $error("not floated");
  property p_oe_on;
    (power_down_n && ce)[*4] |=> serial_lane_oe == '1 && forwarded_clock_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("not driven");
  property p_compl;
    link_locked && serial_lane_oe == '1 |-> serial_lane_out_n == ~serial_lane_out_p &&
      forwarded_clock_out_n == !forwarded_clock_out_p;
  endproperty
  a_compl: assert property (p_compl) else $error("pair not complementary");
  property p_idle;
    !link_locked ##1 !link_locked && serial_lane_oe == '1 |->
      serial_lane_out_p == '0 && serial_lane_out_n == '1;
  endproperty
  a_idle: assert property (p_idle) else $error("unlocked lanes not low");
  property p_loss;
    quiet_q > LOSS_CYC + 8 |-> !link_locked && serial_lane_out_p == '0;
  endproperty
  a_loss: assert property (p_loss) else $error("lock kept without clock");
  property p_fwd_high;
    $rose(forwarded_clock_out_p) && link_locked |->
      (forwarded_clock_out_p || !forwarded_clock_oe)[*8];
  endproperty
  a_fwd_high: assert property (p_fwd_high) else $error("clock high too short");
  property p_fwd_low;
    $fell(forwarded_clock_out_p) && link_locked && forwarded_clock_oe |->
      !forwarded_clock_out_p[*8];
  endproperty
  a_fwd_low: assert property (p_fwd_low) else $error("clock low too short");

  c_lock: cover property ($rose(link_locked));
  c_pd: cover property (!power_down_n && link_locked);
  c_loss: cover property (quiet_q == LOSS_CYC + 9);
endmodule // lvdstx_chk

bind lvdstx_top lvdstx_chk #(.LOSS_CYC (LOSS_CYC)) lvdstx_chk_inst (
  .mclk (mclk), .sys_rst (sys_rst), .ce (ce), .pixel_clock_in (pixel_clock_in),
  .power_down_n (power_down_n), .serial_lane_out_p (serial_lane_out_p),
  .serial_lane_out_n (serial_lane_out_n), .serial_lane_oe (serial_lane_oe),
  .forwarded_clock_out_p (forwarded_clock_out_p), .link_locked (link_locked),
  .forwarded_clock_out_n (forwarded_clock_out_n), .forwarded_clock_oe (forwarded_clock_oe)
);

// ---- lvdstx_src.sv ----
/*
  Graphics source model: 125 ns pixel clock with optional down spread, random
  words launched on the edge opposite the strobe edge.
  Assumes run, rise_cap and ss change only while the clock stands still.
*/
`timescale 1ns/1ps
module lvdstx_src (
  input  wire logic   run,
  input  wire logic   rise_cap,
  input  wire logic   ss,
  output logic        pclk,
  output logic [20:0] word,
  output logic [20:0] cap_word,
  output logic        cap_tgl
);
  integer seed;
  real    dev;
  real    step;

  task automatic edge_to(input logic v);
    #(62.5 + dev / 2.0);
    pclk = v;
    if (v == rise_cap)
    begin
      cap_word = word;
      cap_tgl  = ~cap_tgl;
    end
    else
      word = 21'($random(seed)); // Half a period of setup either way
  endtask

  initial
  begin
    seed     = 32'haca7_b272;
    dev      = 0.0;
    step     = 0.125;
    pclk     = 1'b0;
    word     = '0;
    cap_word = '0;
    cap_tgl  = 1'b0;
    #3.1;
    forever
      if (!run)
        #20 word = 21'($random(seed));
      else
      begin
        edge_to(1'b1);
        edge_to(1'b0);
        // Triangle of 0 to 6 ns on 125 ns, near 80 kHz, slow enough to stay locked
        if (ss && (dev + step > 6.0 || dev + step < 0.0))
          step = -step;
        dev = ss ? dev + step : 0.0;
      end
  end
endmodule // lvdstx_src

// ---- lvds_display_serializer_tx_tb_top.sv ----
/*
  Top bench: source model on the pixel side, a slot decoder rebuilds words
  from the lanes and compares them with the queue of captured words.
  Assumes 200 MHz mclk and shortened loss and lock counts.
*/
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("MISMATCH %0t %s", $time, msg); \
    end \
  end
module lvds_display_serializer_tx_tb_top;
  int          fail_count = 0;
  int          n_checks   = 0;
  int          nd         = 0;
  int          lk         = 0;
  int          rc         = 0;
  logic        mclk       = 1'b0;
  logic        sys_rst    = 1'b1;
  logic        ce         = 1'b1;
  logic        sel        = 1'b0;
  logic        pwr_dn_n   = 1'b1;
  logic        run        = 1'b0;
  logic        ss         = 1'b0;
  logic        pclk, cap_tgl, fwd_p, fwd_n, fwd_oe, locked;
  logic [2:0]  lp, ln, loe;
  logic [20:0] word, cap_word, got;
  logic [6:0]  fw;
  logic [3:0]  hp [25];
  realtime     tq [$];
  logic [20:0] wq [$];

  always #2.5 mclk = ~mclk;

  lvdstx_top #(.LOSS_CYC (100), .LOCK_MAX_CYC (1000)) lvdstx_top_inst (
    .mclk (mclk), .sys_rst (sys_rst), .ce (ce), .pixel_clock_in (pclk),
    .pixel_parallel_in (word), .strobe_edge_select (sel), .power_down_n (pwr_dn_n),
    .serial_lane_out_p (lp), .serial_lane_out_n (ln), .serial_lane_oe (loe),
    .forwarded_clock_out_p (fwd_p), .forwarded_clock_out_n (fwd_n),
    .forwarded_clock_oe (fwd_oe), .link_locked (locked)
  );
  lvdstx_src lvdstx_src_inst (
    .run (run), .rise_cap (sel), .ss (ss), .pclk (pclk), .word (word),
    .cap_word (cap_word), .cap_tgl (cap_tgl)
  );

  always @(cap_tgl)
  begin
    tq.push_back($realtime);
    wq.push_back(cap_word);
  end

  task automatic close_out();
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Spread stretches the slots, so the period is read back from the clock fall (slot 2)
  // to rise (slot 5) span: 10, 11 or 12 cycles mean 25, 26 or 27
  // Each slot is sampled one cycle after its ideal start, counted back from the rise
  task automatic decode();
    int f;
    int p;
    int i;
    f = 0;
    for (int j = 6; j < 24; j++)
      if (f == 0 && !hp[j][3] && hp[j+1][3])
        f = j;
    p = f + 10;
    for (int s = 0; s < 7; s++)
    begin
      i = (5 * p + 6) / 7 + 4 - (s * p + 6) / 7;
      fw[s] = hp[i][3];
      for (int l = 0; l < 3; l++)
        got[7*l+s] = hp[i][l];
    end
    while (tq.size() > 0 && tq[0] < $realtime - 170.0)
    begin
      void'(tq.pop_front());
      void'(wq.pop_front());
    end
    nd++;
    `CHK(fw, lvdstx_pkg::FWD_CLK_PATTERN, "clock slots")
    `CHK(got, wq[0], "word on lanes")
  endtask

  // Outputs are read half a cycle after the edge that launches them
  always @(negedge mclk)
  begin
    for (int i = 24; i > 0; i--)
      hp[i] = hp[i-1];
    hp[0] = {fwd_p, lp};
    lk    = locked ? lk + 1 : 0;
    rc    = (hp[0][3] && !hp[1][3]) ? 0 : rc + 1;
    if (rc == 5 && lk > 40)
      decode();
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wait_lock(input logic v);
    int k;
    k = 0;
    while (locked !== v && k < 1000)
    begin
      tick(1);
      k++;
    end
    `CHK(locked, v, "lock state")
    if (k >= 1000)
      close_out();
  endtask

  initial
  begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    tick(20);
    @(posedge mclk) run <= 1'b1;
    wait_lock(1'b1);
    tick(600);
    `CHK(nd >= 15, 1'b1, "falling edge words")
    @(posedge mclk) run <= 1'b0;
    wait_lock(1'b0);
    tick(20);
    `CHK({lp, ln, loe, fwd_oe}, {3'h0, 3'h7, 3'h7, 1'b1}, "idle lanes")
    @(posedge mclk) sel <= 1'b1;
    ss  <= 1'b1;
    run <= 1'b1;
    nd = 0;
    wait_lock(1'b1);
    tick(1500);
    `CHK(nd >= 45, 1'b1, "spread words")
    @(posedge mclk) pwr_dn_n <= 1'b0;
    tick(4);
    `CHK({lp, ln, loe, fwd_p, fwd_n, fwd_oe, locked}, 13'h0000, "power-down")
    tick(200);
    @(posedge mclk) pwr_dn_n <= 1'b1;
    wait_lock(1'b1);
    tick(300);
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    close_out();
  end
endmodule // lvds_display_serializer_tx_tb_top
